// ==== rtl/cio_pkg.sv ====
package cio_pkg;

  // Port indices A..G
  localparam int NUM_PORTS = 7;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;
  localparam logic [7:0] PORT_D_MASK = 8'h0f;

  // Register kinds, byte address = base + kind*0x40 + port*4
  localparam logic [3:0] KIND_DATA_IN = 4'h0;
  localparam logic [3:0] KIND_DATA_OUT = 4'h1;
  localparam logic [3:0] KIND_DIRECTION = 4'h2;
  localparam logic [3:0] KIND_CONTROL = 4'h3;
  localparam logic [3:0] KIND_DRIVE = 4'h4;
  localparam logic [3:0] KIND_MACROCELL = 4'h5;
  localparam logic [3:0] KIND_INPUT_MC = 4'h6;
  localparam logic [3:0] KIND_MISC = 4'h7;
  localparam int KIND_LSB = 6;
  localparam int PORT_LSB = 2;

  // Misc registers (port field of KIND_MISC)
  localparam logic [2:0] MISC_MEMMAP = 3'h0;
  localparam logic [2:0] MISC_BUSTYPE = 3'h1;
  localparam logic [2:0] MISC_JTAG = 3'h2;
  localparam int PIO_BIT = 7;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Latched address layout on output ports
  typedef enum logic [1:0] {
    CIO_BUS_MUX = 2'b00,
    CIO_BUS_BURST = 2'b01,
    CIO_BUS_PAGE = 2'b11,
    CIO_BUS_NONMUX = 2'b10
  } cio_bus_type;

  // Fixed-at-programming configuration per port
  typedef struct packed {
    logic [7:0] pld_out;
    logic [7:0] oe_defined;
    logic [1:0] imc_mode;
    logic imc_clk_pt;
    logic addr_in;
  } cio_fixcfg_type;

  localparam logic [1:0] IMC_DIRECT = 2'h0;
  localparam logic [1:0] IMC_LATCH = 2'h1;
  localparam logic [1:0] IMC_REG = 2'h2;

  // Bus request captured in address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } cio_req_type;

endpackage : cio_pkg

// ==== rtl/cio_input_mc.sv ====
`timescale 1ns/1ps
`default_nettype none
module cio_input_mc #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [1:0] mode_in,
  input wire logic clk_sel_pt_in,
  input wire logic strobe_in,
  input wire logic pt_clk_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] mc_out
);
  logic [WIDTH-1:0] store_q, store_d;
  logic en, en_prev_q, en_prev_d;

  always_comb begin
    en = clk_sel_pt_in ? pt_clk_in : strobe_in;
    en_prev_d = en;
    store_d = store_q;
    if (mode_in == cio_pkg::IMC_LATCH && en) begin
      store_d = pins_in;
    end else if (mode_in == cio_pkg::IMC_REG && en && !en_prev_q) begin
      store_d = pins_in;
    end
    mc_out = (mode_in == cio_pkg::IMC_DIRECT) ? pins_in : store_q;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      store_q <= '0;
      en_prev_q <= 1'b0;
    end else begin
      store_q <= store_d;
      en_prev_q <= en_prev_d;
    end
  end
endmodule : cio_input_mc
`default_nettype wire

// ==== rtl/cio_port_block.sv ====
// Function
// - Seven ports, port D four pins
// - Output mux: data, address, macrocell, selects
// - Readback buffer returns one source
// - Driver enable is product term OR direction
// - Direction alone rules without product term
// - Input macrocells: latch, register, direct
// - Input macrocells feed PLD and readback
// - Fixed modes from programming, others run-time
// - Port registers mapped on the bus
// - Control zero selects processor I/O mode
// - Output from data-out, input via data-in
// - Ports A-D lack control, processor I/O
// - Address out by enable or direction&control
// - Address nibbles follow bus type
// - Address input on A-D and F
// - JTAG on port E, three enables
// - Peripheral mode on F via memory-map bit
// - Registers reset to zero, bit per pin
// - Direction one output, zero input
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cio_port_block #(
  parameter int NPORT = 7,
  parameter int ADDR_W = 12
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [ADDR_W-1:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Fixed programming configuration per port
  input wire cio_pkg::cio_fixcfg_type [NPORT-1:0] FIXCFG_IN,
  // PLD side
  input wire logic [NPORT-1:0][7:0] MACROCELL_IN,
  input wire logic [NPORT-1:0][7:0] OE_TERM_IN,
  input wire logic [2:0] EXTERNAL_CHIP_SELECTS_IN,
  input wire logic [2:0] IMC_CLK_TERM_IN,
  input wire logic PERIPHERAL_SELECT_ZERO_IN,
  input wire logic PERIPHERAL_SELECT_ONE_IN,
  input wire logic [7:0] PERIPH_DATA_IN,
  input wire logic PERIPH_READ_IN,
  input wire logic [15:0] LATCHED_ADDR_IN,
  input wire logic ADDRESS_LATCH_STROBE_IN,
  input wire logic JTAG_PIN_EN_IN,
  input wire logic JTAG_ISP_EN_IN,
  output logic [2:0][7:0] INPUT_MACROCELL_OUT,
  output logic [7:0] ADDR_IN_BUS_OUT,
  output logic [7:0] PERIPH_DATA_OUT,
  output logic JTAG_ACTIVE_OUT,
  // Pins
  input wire logic [NPORT-1:0][7:0] PIN_IN,
  output logic [NPORT-1:0][7:0] PIN_OUT,
  output logic [NPORT-1:0][7:0] PIN_OEN_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and pin synchronisers
  logic [NPORT-1:0][7:0] dout_q, dout_d, dir_q, dir_d, drv_q, drv_d;
  logic [NPORT-1:0][7:0] ctl_q, ctl_d;
  logic [7:0] memmap_q, memmap_d, jtag_q, jtag_d;
  cio_pkg::cio_bus_type bus_q, bus_d;
  logic [NPORT-1:0][7:0] pin_s1_q, pin_s2_q;
  logic [2:0] strobe_s_q;
  cio_pkg::cio_req_type req_q, req_d;
  logic [31:0] rdata_q, rdata_d;
  logic [NPORT-1:0][7:0] drive_en, mux_val;
  logic [2:0][7:0] imc_val;

  function automatic logic [7:0] port_mask(input int p);
    port_mask = (p == cio_pkg::PORT_D) ? cio_pkg::PORT_D_MASK : 8'hff;
  endfunction : port_mask

  function automatic logic has_ctl(input int p);
    has_ctl = (p >= cio_pkg::PORT_E);
  endfunction : has_ctl

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      strobe_s_q <= '0;
    end else begin
      pin_s1_q <= PIN_IN;
      pin_s2_q <= pin_s1_q;
      strobe_s_q <= {strobe_s_q[1:0], ADDRESS_LATCH_STROBE_IN};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input macrocells on ports A to C
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_imc
      cio_input_mc #(.WIDTH(8)) u_imc (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .mode_in(FIXCFG_IN[g].imc_mode),
        .clk_sel_pt_in(FIXCFG_IN[g].imc_clk_pt),
        .strobe_in(strobe_s_q[2]),
        .pt_clk_in(IMC_CLK_TERM_IN[g]),
        .pins_in(pin_s2_q[g]),
        .mc_out(imc_val[g])
      );
    end
  endgenerate
  assign INPUT_MACROCELL_OUT = imc_val;

  ////////////////////////////////////////////////////////////////////////
  // Latched address nibbles per port and bus type
  function automatic logic [7:0] addr_byte(input int p, input cio_pkg::cio_bus_type b,
                                           input logic [15:0] a);
    addr_byte = 8'h00;
    case (b)
      cio_pkg::CIO_BUS_MUX: addr_byte = a[7:0];
      cio_pkg::CIO_BUS_BURST: addr_byte = (p == cio_pkg::PORT_G) ? a[15:8] : {a[7:4], 4'h0};
      cio_pkg::CIO_BUS_PAGE: addr_byte = (p == cio_pkg::PORT_G) ? {a[7:4], a[11:8]} : 8'h00;
      cio_pkg::CIO_BUS_NONMUX: addr_byte = (p == cio_pkg::PORT_G) ? a[7:0] : 8'h00;
      default: addr_byte = 8'h00;
    endcase
  endfunction : addr_byte

  ////////////////////////////////////////////////////////////////////////
  // Output mux and driver enables
  logic pio_on, psel_any;
  logic [NPORT-1:0][7:0] addr_val;
  always_comb begin
    pio_on = memmap_q[cio_pkg::PIO_BIT];
    psel_any = PERIPHERAL_SELECT_ZERO_IN | PERIPHERAL_SELECT_ONE_IN;
    for (int p = 0; p < NPORT; p++) begin
      addr_val[p] = addr_byte(p, bus_q, LATCHED_ADDR_IN);
      for (int b = 0; b < 8; b++) begin
        // Enable term only counts where the pin has one defined
        drive_en[p][b] = dir_q[p][b]
          | (FIXCFG_IN[p].oe_defined[b] & OE_TERM_IN[p][b]);
        mux_val[p][b] = dout_q[p][b];
        if (FIXCFG_IN[p].pld_out[b]) begin
          mux_val[p][b] = MACROCELL_IN[p][b];
        end
        if (p == cio_pkg::PORT_D && b < 3) begin
          mux_val[p][b] = FIXCFG_IN[p].pld_out[b] ? EXTERNAL_CHIP_SELECTS_IN[b]
                                                  : dout_q[p][b];
        end
        if (has_ctl(p) && ctl_q[p][b]) begin
          mux_val[p][b] = addr_val[p][b];
          drive_en[p][b] = dir_q[p][b] | (FIXCFG_IN[p].oe_defined[b] & OE_TERM_IN[p][b]);
        end
      end
      drive_en[p] = drive_en[p] & port_mask(p);
    end
    // Peripheral buffer on port F
    if (pio_on) begin
      mux_val[cio_pkg::PORT_F] = PERIPH_DATA_IN;
      drive_en[cio_pkg::PORT_F] = (psel_any && PERIPH_READ_IN) ? 8'hff : 8'h00;
    end
    // JTAG keeps port E pins 0..5 while active
    if (JTAG_ACTIVE_OUT) begin
      drive_en[cio_pkg::PORT_E][5:0] = 6'h00;
    end
  end

  always_comb begin
    JTAG_ACTIVE_OUT = JTAG_PIN_EN_IN | JTAG_ISP_EN_IN | jtag_q[0];
    PERIPH_DATA_OUT = (pio_on && psel_any) ? pin_s2_q[cio_pkg::PORT_F] : 8'h00;
    ADDR_IN_BUS_OUT = 8'h00;
    for (int p = 0; p < NPORT; p++) begin
      if (FIXCFG_IN[p].addr_in && p != cio_pkg::PORT_E && p != cio_pkg::PORT_G) begin
        ADDR_IN_BUS_OUT = ADDR_IN_BUS_OUT
          | ((p < 3) ? imc_val[p % 3] : pin_s2_q[p]) & port_mask(p);
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PIN_OUT <= '0;
      PIN_OEN_OUT <= '1;
    end else begin
      PIN_OUT <= mux_val;
      PIN_OEN_OUT <= ~drive_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  logic [3:0] kind;
  logic [2:0] pidx;
  logic [7:0] wbyte, rbyte;
  always_comb begin
    req_d.valid = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    req_d.write = HWRITE_IN;
    req_d.addr = HADDR_IN[11:0];
    kind = req_q.addr[9:6];
    pidx = req_q.addr[4:2];
    wbyte = HWDATA_IN[7:0];
    dout_d = dout_q;
    dir_d = dir_q;
    ctl_d = ctl_q;
    drv_d = drv_q;
    memmap_d = memmap_q;
    jtag_d = jtag_q;
    bus_d = bus_q;
    rbyte = 8'h00;
    if (req_q.valid && pidx < 3'(NPORT) && req_q.addr[11:10] == 2'b00
        && !req_q.addr[5]) begin
      case (kind)
        cio_pkg::KIND_DATA_IN: rbyte = pin_s2_q[pidx] & port_mask(int'(pidx));
        cio_pkg::KIND_DATA_OUT: rbyte = dout_q[pidx];
        cio_pkg::KIND_DIRECTION: rbyte = dir_q[pidx];
        cio_pkg::KIND_CONTROL: rbyte = ctl_q[pidx];
        cio_pkg::KIND_DRIVE: rbyte = drv_q[pidx];
        cio_pkg::KIND_MACROCELL: rbyte = MACROCELL_IN[pidx];
        cio_pkg::KIND_INPUT_MC: rbyte = (pidx < 3) ? imc_val[pidx % 3] : 8'h00;
        cio_pkg::KIND_MISC: begin
          case (pidx)
            cio_pkg::MISC_MEMMAP: rbyte = memmap_q;
            cio_pkg::MISC_BUSTYPE: rbyte = {6'h00, bus_q};
            cio_pkg::MISC_JTAG: rbyte = jtag_q;
            default: rbyte = 8'h00;
          endcase
        end
        default: rbyte = 8'h00;
      endcase
      if (req_q.write) begin
        case (kind) // only run-time registers are writable
          cio_pkg::KIND_DATA_OUT: dout_d[pidx] = wbyte & port_mask(int'(pidx));
          cio_pkg::KIND_DIRECTION: dir_d[pidx] = wbyte & port_mask(int'(pidx));
          cio_pkg::KIND_CONTROL: begin
            if (has_ctl(int'(pidx))) begin
              ctl_d[pidx] = wbyte;
            end
          end
          cio_pkg::KIND_DRIVE: drv_d[pidx] = wbyte & port_mask(int'(pidx));
          cio_pkg::KIND_MISC: begin
            case (pidx)
              cio_pkg::MISC_MEMMAP: memmap_d = wbyte;
              cio_pkg::MISC_BUSTYPE: bus_d = cio_pkg::cio_bus_type'(wbyte[1:0]);
              cio_pkg::MISC_JTAG: jtag_d = {7'h00, wbyte[0]};
              default: jtag_d = jtag_q;
            endcase
          end
          default: dout_d = dout_q;
        endcase
      end
    end
    rdata_d = (req_d.valid && !HWRITE_IN) ? 32'h0 : rdata_q;
    if (req_q.valid && !req_q.write) begin
      rdata_d = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      req_q <= '0;
      rdata_q <= '0;
      dout_q <= '0;
      dir_q <= '0;
      ctl_q <= '0;
      drv_q <= '0;
      memmap_q <= cio_pkg::REG_RESET;
      jtag_q <= cio_pkg::REG_RESET;
      bus_q <= cio_pkg::CIO_BUS_MUX;
    end else begin
      req_q <= req_d;
      rdata_q <= rdata_d;
      dout_q <= dout_d;
      dir_q <= dir_d;
      ctl_q <= ctl_d;
      drv_q <= drv_d;
      memmap_q <= memmap_d;
      jtag_q <= jtag_d;
      bus_q <= bus_d;
    end
  end

  assign HREADYOUT_OUT = !(req_q.valid && !req_q.write);
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  dir_reset_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(RESETN_IN) |-> dir_q == '0) else $error("direction not zero");
  oe_or_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (!pio_on && !JTAG_ACTIVE_OUT && dir_q[cio_pkg::PORT_A][0])
      |=> !PIN_OEN_OUT[cio_pkg::PORT_A][0]) else $error("pin not driven");
  dir_alone_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (!FIXCFG_IN[cio_pkg::PORT_B].oe_defined[1] && !dir_q[cio_pkg::PORT_B][1])
      |=> PIN_OEN_OUT[cio_pkg::PORT_B][1]) else $error("pin driven");
  port_d_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    PIN_OEN_OUT[cio_pkg::PORT_D][7:4] == 4'hf) else $error("port D upper driven");
  ctl_abc_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    ctl_q[2:0] == '0) else $error("control on A-C");
  mcu_out_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (ctl_q[cio_pkg::PORT_E][7] == 1'b0 && !FIXCFG_IN[cio_pkg::PORT_E].pld_out[7])
      |=> PIN_OUT[cio_pkg::PORT_E][7] == $past(dout_q[cio_pkg::PORT_E][7]))
    else $error("data out not on pin");
  addr_out_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (ctl_q[cio_pkg::PORT_G][0] && dir_q[cio_pkg::PORT_G][0]) |=> !PIN_OEN_OUT[cio_pkg::PORT_G][0])
    else $error("address pin not driven");
  pio_tri_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (pio_on && !psel_any) |=> PIN_OEN_OUT[cio_pkg::PORT_F] == 8'hff)
    else $error("peripheral buffer driven");
  read_wait_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (req_q.valid && !req_q.write) |-> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
    else $error("read wait wrong");

endmodule : cio_port_block
`default_nettype wire

// ==== bench/cio_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cio_pin_model (
  input wire logic [6:0][7:0] pin_out_in,
  input wire logic [6:0][7:0] pin_oen_in,
  input wire logic [6:0][7:0] ext_in,
  output logic [6:0][7:0] pin_in_out
);
  // Outside drivers only act on pins the block has released
  assign pin_in_out = (pin_oen_in & ext_in) | (~pin_oen_in & pin_out_in);
endmodule : cio_pin_model
`default_nettype wire

// ==== bench/cio_port_block_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cio_port_block_tb;
  logic clk_in = 1'b0;
  logic rstn, hsel, hwrite, hreadyout, hresp, peripheral_select_zero, peripheral_select_one, pread, strobe, jpin, jisp, jact, rd_ph;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, ecs, imc_clk;
  logic [31:0] hwdata, hrdata;
  cio_pkg::cio_fixcfg_type [6:0] fixcfg;
  logic [6:0][7:0] mc, oe_term, pin_in, pin_out, pin_oen, ext;
  logic [2:0][7:0] imc_out;
  logic [7:0] addr_bus, pdout, pdata, d, e;
  logic [15:0] laddr;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int seed;
  ////////////////////////////////////////////////////////////////////////////
  always #4 clk_in = ~clk_in;
  cio_port_block dut (.CLK_IN(clk_in), .RESETN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp),
    .FIXCFG_IN(fixcfg), .MACROCELL_IN(mc), .OE_TERM_IN(oe_term), .EXTERNAL_CHIP_SELECTS_IN(ecs),
    .IMC_CLK_TERM_IN(imc_clk), .PERIPHERAL_SELECT_ZERO_IN(peripheral_select_zero),
    .PERIPHERAL_SELECT_ONE_IN(peripheral_select_one), .PERIPH_DATA_IN(pdata), .PERIPH_READ_IN(pread),
    .LATCHED_ADDR_IN(laddr), .ADDRESS_LATCH_STROBE_IN(strobe), .JTAG_PIN_EN_IN(jpin),
    .JTAG_ISP_EN_IN(jisp), .INPUT_MACROCELL_OUT(imc_out), .ADDR_IN_BUS_OUT(addr_bus),
    .PERIPH_DATA_OUT(pdout), .JTAG_ACTIVE_OUT(jact), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OEN_OUT(pin_oen));
  cio_pin_model pins (.pin_out_in(pin_out), .pin_oen_in(pin_oen), .ext_in(ext),
    .pin_in_out(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [11:0] ra(input int k, input int p);
    return 12'((k << 6) | (p << 2));
  endfunction : ra
  task automatic wait_ready();
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_in);
      if (hreadyout === 1'b1) return;
    end
    n_mismatch++;
    final_report();
  endtask : wait_ready
  // Single word transfer; read expectation goes on the queue
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                     input logic [7:0] ex);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    if (!wr) exp_q.push_back({24'h0, ex});
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    wait_ready();
  endtask : bus
  task automatic settle();
    repeat (4) @(posedge clk_in);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  // Read data monitor
  always @(posedge clk_in) begin
    if (rd_ph && hreadyout) begin
      if (exp_q.size() == 0) check(hrdata, 32'hffffffff);
      else check(hrdata, exp_q.pop_front());
    end
    if (!rstn) rd_ph <= 1'b0;
    else if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 11740;
    {rstn, hsel, hwrite, peripheral_select_zero, peripheral_select_one, pread, strobe, jpin, jisp} = '0;
    {haddr, htrans, ecs, imc_clk, hwdata, mc, oe_term, ext, pdata} = '0;
    hsize = 3'h2;
    fixcfg = '0;
    laddr = 16'($random(seed));
    repeat (8) @(posedge clk_in);
    rstn <= 1'b1;
    @(posedge clk_in);
    for (int p = 0; p < 7; p++) begin
      check(pin_oen[p], 8'hff);
      bus(1'b0, ra(1, p), 8'h00, 8'h00);
      bus(1'b0, ra(2, p), 8'h00, 8'h00);
      if (p > 3) bus(1'b0, ra(3, p), 8'h00, 8'h00);
    end
    // Port A half output, half input
    d = 8'($random(seed));
    e = 8'($random(seed));
    ext[0] <= e;
    bus(1'b1, ra(1, 0), d, 8'h00);
    bus(1'b1, ra(2, 0), 8'h0f, 8'h00);
    settle();
    check(pin_out[0] & 8'h0f, d & 8'h0f);
    check(pin_oen[0], 8'hf0);
    check(imc_out[0], (e & 8'hf0) | (d & 8'h0f));
    bus(1'b0, ra(0, 0), 8'h00, (e & 8'hf0) | (d & 8'h0f));
    bus(1'b0, ra(6, 0), 8'h00, (e & 8'hf0) | (d & 8'h0f));
    bus(1'b0, ra(1, 0), 8'h00, d);
    bus(1'b0, ra(2, 0), 8'h00, 8'h0f);
    bus(1'b1, ra(3, 0), 8'hff, 8'h00);
    bus(1'b0, ra(3, 0), 8'h00, 8'h00);
    bus(1'b1, ra(2, 3), 8'hff, 8'h00);
    bus(1'b0, ra(2, 3), 8'h00, 8'h0f);
    fixcfg[1].oe_defined <= 8'hff;
    oe_term[1] <= 8'h3c;
    oe_term[2] <= 8'hff;
    settle();
    check(pin_oen[3], 8'hf0);
    check(pin_oen[1], 8'hc3);
    check(pin_oen[2], 8'hff);
    check(addr_bus, 8'h00);
    // Address input, macrocell and chip-select outputs
    fixcfg[0].addr_in <= 1'b1;
    fixcfg[2].pld_out <= 8'hff;
    fixcfg[3].pld_out <= 8'h07;
    mc[2] <= 8'($random(seed));
    ecs <= 3'($random(seed));
    settle();
    check(addr_bus, (e & 8'hf0) | (d & 8'h0f));
    check(pin_out[2], mc[2]);
    check(pin_out[3] & 8'h07, {5'h00, ecs});
    bus(1'b0, ra(5, 2), 8'h00, mc[2]);
    // Port A macrocell as register, then as latch
    fixcfg[0].imc_mode <= cio_pkg::IMC_REG;
    fixcfg[0].imc_clk_pt <= 1'b1;
    settle();
    check(imc_out[0], 8'h00);
    imc_clk[0] <= 1'b1;
    settle();
    check(imc_out[0], (e & 8'hf0) | (d & 8'h0f));
    fixcfg[0].imc_mode <= cio_pkg::IMC_LATCH;
    fixcfg[0].imc_clk_pt <= 1'b0;
    ext[0] <= ~e;
    settle();
    check(imc_out[0], (e & 8'hf0) | (d & 8'h0f));
    strobe <= 1'b1;
    settle();
    settle();
    check(imc_out[0], (~e & 8'hf0) | (d & 8'h0f));
    // Address out on port G, every bus type
    d = 8'($random(seed));
    bus(1'b1, ra(1, 6), d, 8'h00);
    bus(1'b1, ra(2, 6), 8'hff, 8'h00);
    bus(1'b1, ra(3, 6), 8'hff, 8'h00);
    for (int bt = 0; bt < 4; bt++) begin
      bus(1'b1, ra(7, 1), 8'(bt), 8'h00);
      settle();
      case (bt)
        1: check(pin_out[6], laddr[15:8]);
        3: check(pin_out[6], {laddr[7:4], laddr[11:8]});
        default: check(pin_out[6], laddr[7:0]);
      endcase
      check(pin_oen[6], 8'h00);
    end
    bus(1'b1, ra(7, 1), 8'h00, 8'h00);
    bus(1'b1, ra(3, 6), 8'h00, 8'h00);
    settle();
    check(pin_out[6], d);
    // Peripheral buffer on port F
    bus(1'b1, ra(7, 0), 8'h80, 8'h00);
    bus(1'b0, ra(7, 0), 8'h00, 8'h80);
    pdata <= 8'($random(seed));
    peripheral_select_one <= 1'b1;
    pread <= 1'b1;
    settle();
    check(pin_out[5], pdata);
    check(pin_oen[5], 8'h00);
    check(pdout, pdata);
    peripheral_select_one <= 1'b0;
    settle();
    check(pin_oen[5], 8'hff);
    check(pdout, 8'h00);
    // Each JTAG enable method alone
    jpin <= 1'b1;
    settle();
    check(jact, 1'b1);
    jpin <= 1'b0;
    jisp <= 1'b1;
    settle();
    check(jact, 1'b1);
    jisp <= 1'b0;
    bus(1'b1, ra(7, 2), 8'h01, 8'h00);
    settle();
    check(jact, 1'b1);
    bus(1'b1, ra(7, 2), 8'h00, 8'h00);
    settle();
    check(jact, 1'b0);
    bus(1'b1, 12'hffc, 8'hff, 8'h00);
    bus(1'b0, 12'hffc, 8'h00, 8'h00);
    settle();
    check(32'(exp_q.size()), 32'h0);
    final_report();
  end
endmodule : cio_port_block_tb
`default_nettype wire
